// >>> asrp_pkg.sv
package asrp_pkg;
   // ****************************************
   // Frame geometry
   // ****************************************
   localparam int RESULT_BITS = 10;
   localparam int CMD_BITS = 2;
   // Sampling clocks between channel bit and first result bit
   localparam int SAMPLE_CLKS = 1;
   localparam int FRAME_CLKS = 16;
   localparam int BYTE_BITS = 8;
   localparam logic [7:0] FIRST_BYTE_MASK = 8'h03;
   // Serial clock half period in system clocks
   localparam int SCLK_HALF = 4;
   // Idle system clocks between frames, chip select high
   localparam int GAP_CLKS = 8;
endpackage

// >>> asrp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface asrp_if;
   logic sclk;
   logic cs_n;
   logic host_dat;
   logic host_dat_oe;
   logic dev_dat;
   logic dev_dat_oe;
   logic line;
   // Shared data wire: driven value if any driver, else divider level 1
   assign line = host_dat_oe ? host_dat : (dev_dat_oe ? dev_dat : 1'b1);
   modport dev (input sclk, input cs_n, input line, output dev_dat, output dev_dat_oe);
   modport host (output sclk, output cs_n, output host_dat, output host_dat_oe, input line);
endinterface
`default_nettype wire

// >>> asrp_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Two bytes: command plus top bits, then eight
// - Result starts at fixed count after start
// - Host masks first byte to two bits
// - Host sends start bit then one channel bit
// - Data in and out may share wire
// - Zeros follow last bit until deselect
// - Output released while idle
// - Auto low power after each conversion
// - Sixteen clock frames, chip select toggles
// - One approximation bit per serial clock
module asrp_dev
(
   // System
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Link
   asrp_if.dev lnk,
   // Analog stand-in
   input wire logic [1:0][asrp_pkg::RESULT_BITS-1:0] i_sample,
   // Status
   output logic o_powered,
   output logic [asrp_pkg::RESULT_BITS-1:0] o_last_result
);
   typedef enum logic [2:0] {ST_IDLE, ST_START, ST_ADDR, ST_SAMPLE, ST_CONV, ST_TAIL} asrp_st_t;
   asrp_st_t st_q;
   logic sclk_q, rise, fall;
   logic [3:0] cnt_q;
   logic [3:0] bit_idx;
   logic ch_q;
   logic [asrp_pkg::RESULT_BITS-1:0] held_q, sar_q;
   logic dout_q, oe_q;

   // ****************************************
   // Edge detection of the host clock
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      sclk_q <= lnk.sclk;
   end
   assign rise = lnk.sclk & ~sclk_q & ~lnk.cs_n;
   assign fall = ~lnk.sclk & sclk_q & ~lnk.cs_n;

   // Command capture and conversion sequencing
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || lnk.cs_n)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         ch_q <= 1'b0;
      end
      else if (rise)
      begin
         unique case (st_q)
            ST_IDLE: if (lnk.line) st_q <= ST_ADDR;
            ST_START: st_q <= ST_ADDR;
            ST_ADDR:
            begin
               ch_q <= lnk.line;
               st_q <= ST_SAMPLE;
               cnt_q <= 4'h0;
            end
            ST_SAMPLE:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(asrp_pkg::SAMPLE_CLKS - 1))
               begin
                  st_q <= ST_CONV;
                  cnt_q <= 4'h0;
               end
            end
            ST_CONV:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(asrp_pkg::RESULT_BITS - 1))
                  st_q <= ST_TAIL;
            end
            ST_TAIL: st_q <= ST_TAIL;
         endcase
      end
   end

   // Result bit resolved in the current conversion step, MSB first
   assign bit_idx = 4'(asrp_pkg::RESULT_BITS - 1) - cnt_q;

   // Sample hold and successive result register, one bit per clock
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         held_q <= '0;
         sar_q <= '0;
         o_last_result <= '0;
      end
      else if (rise && st_q == ST_SAMPLE && cnt_q == 4'h0)
      begin
         held_q <= i_sample[ch_q];
         sar_q <= '0;
      end
      else if (fall && st_q == ST_CONV)
         sar_q[bit_idx] <= held_q[bit_idx];
      else if (rise && st_q == ST_CONV && cnt_q == 4'(asrp_pkg::RESULT_BITS - 1))
         o_last_result <= sar_q;
   end

   // ****************************************
   // Serial output, updated after falling edge
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || lnk.cs_n)
      begin
         dout_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (fall)
      begin
         if (st_q == ST_CONV)
         begin
            oe_q <= 1'b1;
            dout_q <= held_q[bit_idx];
         end
         else if (st_q == ST_TAIL)
            dout_q <= 1'b0;
      end
   end
   assign lnk.dev_dat = dout_q;
   assign lnk.dev_dat_oe = oe_q;

   // Powered only while a frame is under way
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         o_powered <= 1'b0;
      else
         o_powered <= ~lnk.cs_n && st_q != ST_TAIL;
   end
endmodule
`default_nettype wire

// >>> asrp_host.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_host
(
   // System
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Link
   asrp_if.host lnk,
   // User side
   input wire logic i_start,
   input wire logic i_chan,
   input wire logic i_continuous,
   output logic o_busy,
   output logic o_valid,
   output logic [7:0] o_byte_hi,
   output logic [7:0] o_byte_lo
);
   typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} asrp_hst_t;
   asrp_hst_t st_q;
   logic [2:0] div_q;
   logic [4:0] bit_q;
   logic [3:0] gap_q;
   logic [15:0] cmd_q, rx_q;
   logic sclk_q, cont_q;

   // ****************************************
   // Frame engine: sixteen clocks per frame
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         st_q <= H_IDLE;
         div_q <= '0;
         bit_q <= '0;
         gap_q <= '0;
         sclk_q <= 1'b0;
         cmd_q <= '0;
         rx_q <= '0;
         cont_q <= 1'b0;
         o_valid <= 1'b0;
         o_byte_hi <= '0;
         o_byte_lo <= '0;
      end
      else
      begin
         o_valid <= 1'b0;
         unique case (st_q)
            H_IDLE:
               if (i_start)
               begin
                  // Start bit placed so result is right aligned
                  cmd_q <= {3'b000, 1'b1, i_chan, 11'h000};
                  cont_q <= i_continuous;
                  st_q <= H_RUN;
                  div_q <= '0;
                  bit_q <= '0;
               end
            H_RUN:
            begin
               div_q <= div_q + 3'h1;
               if (div_q == 3'(asrp_pkg::SCLK_HALF - 1))
               begin
                  div_q <= '0;
                  sclk_q <= ~sclk_q;
                  if (!sclk_q)
                     rx_q <= {rx_q[14:0], lnk.line};
                  else
                  begin
                     cmd_q <= {cmd_q[14:0], 1'b0};
                     bit_q <= bit_q + 5'h1;
                     if (bit_q == 5'(asrp_pkg::FRAME_CLKS - 1))
                     begin
                        st_q <= H_GAP;
                        gap_q <= '0;
                        o_valid <= 1'b1;
                        o_byte_hi <= rx_q[15:8] & asrp_pkg::FIRST_BYTE_MASK;
                        o_byte_lo <= rx_q[7:0];
                     end
                  end
               end
            end
            H_GAP:
            begin
               // Continuous mode may be left between frames
               cont_q <= i_continuous;
               gap_q <= gap_q + 4'h1;
               if (gap_q == 4'(asrp_pkg::GAP_CLKS - 1))
               begin
                  st_q <= (cont_q || i_start) ? H_RUN : H_IDLE;
                  bit_q <= '0;
                  cmd_q <= {3'b000, 1'b1, i_chan, 11'h000};
               end
            end
         endcase
      end
   end

   assign lnk.sclk = sclk_q;
   assign lnk.cs_n = (st_q != H_RUN);
   // Drive command bits, then release for the result
   assign lnk.host_dat = cmd_q[15];
   assign lnk.host_dat_oe = (st_q == H_RUN) && (bit_q < 5'h05);
   assign o_busy = (st_q != H_IDLE);
endmodule
`default_nettype wire

// >>> asrp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module asrp_chk
(
   // System
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic host_dat_oe,
   input wire logic dev_dat,
   input wire logic dev_dat_oe
);
   // ****
   // Frame checks
   // ****
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic [4:0] n_rise_q;
   // Serial clock rises in open frame
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst || cs_n)
         n_rise_q <= 5'h00;
      else if ($rose(sclk))
         n_rise_q <= n_rise_q + 5'h01;
   end
   AST_ONE_DRIVER: assert property (!(host_dat_oe && dev_dat_oe))
      else $error("both drive line");
   AST_DEV_IDLE_OFF: assert property (cs_n ##1 cs_n |-> !dev_dat_oe)
      else $error("device drives while idle");
   AST_HOST_IDLE_OFF: assert property (cs_n ##1 cs_n |-> !host_dat_oe)
      else $error("host drives while idle");
   AST_SCLK_STILL: assert property (cs_n[*3] |-> $stable(sclk))
      else $error("serial clock moves while idle");
   AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
      else $error("serial clock high time wrong");
   AST_DEV_ON_FALL: assert property (dev_dat_oe && $past(dev_dat_oe) && $changed(dev_dat)
      |-> !sclk)
      else $error("device output moves while clock high");
   AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*8])
      else $error("select gap too short");
   AST_FRAME_16: assert property ($rose(cs_n) |-> n_rise_q == 5'h10)
      else $error("frame not sixteen clocks");
endmodule
`default_nettype wire

// >>> adc_serial_result_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_result_port_tb;
   // ****
   // Bench
   // ****
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_start = 1'b0;
   logic i_chan = 1'b0;
   logic i_continuous = 1'b0;
   logic [1:0][9:0] i_sample = 20'h00000;
   logic o_busy, o_valid, o_powered;
   logic [7:0] o_byte_hi, o_byte_lo;
   logic [9:0] o_last;
   logic [15:0] fr_q = 16'h0000;
   int n_fail = 0;
   int n_checks = 0;
   asrp_if lnk ();
   asrp_dev u_asrp_dev (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .lnk(lnk), .i_sample(i_sample),
      .o_powered(o_powered), .o_last_result(o_last));
   asrp_host u_asrp_host (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .lnk(lnk), .i_start(i_start),
      .i_chan(i_chan), .i_continuous(i_continuous), .o_busy(o_busy), .o_valid(o_valid),
      .o_byte_hi(o_byte_hi), .o_byte_lo(o_byte_lo));
   asrp_chk u_asrp_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .sclk(lnk.sclk),
      .cs_n(lnk.cs_n), .host_dat_oe(lnk.host_dat_oe), .dev_dat(lnk.dev_dat),
      .dev_dat_oe(lnk.dev_dat_oe));
   // Clock
   always #2.5 i_clk = ~i_clk;
   // Wire bits taken at each serial clock rise
   always @(posedge lnk.sclk) fr_q <= {fr_q[14:0], lnk.line};
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("Checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Bounded wait for idle or for a result
   task automatic wait_on(input bit idle);
      for (int k = 0; k < 400; k++)
      begin
         @(negedge i_clk);
         if (idle ? o_busy === 1'b0 : o_valid === 1'b1)
            return;
      end
      n_fail++;
      stop_test();
   endtask
   task automatic check_frame(input logic chan, input logic [9:0] val);
      check({8'h00, o_byte_hi}, {14'h0000, val[9:8]});
      check({8'h00, o_byte_lo}, {8'h00, val[7:0]});
      check(fr_q & 16'hfbff, {4'h1, chan, 1'b0, val});
      check({6'h00, o_last}, {6'h00, val});
      check({15'h0000, o_powered}, 16'h0000);
      $display("Test chan %0d value %h done", chan, val);
   endtask
   task automatic run(input logic chan, input logic [9:0] val, input logic cont);
      wait_on(1'b1);
      check({15'h0000, o_powered}, 16'h0000);
      i_chan = chan;
      i_continuous = cont;
      i_sample[chan] = val;
      i_start = 1'b1;
      @(negedge i_clk);
      i_start = 1'b0;
      wait_on(1'b0);
      check_frame(chan, val);
   endtask
   // Sequence
   initial
   begin
      repeat (6) @(negedge i_clk);
      i_sys_rst = 1'b0;
      run(1'b0, 10'h249, 1'b0);
      run(1'b1, 10'h3ff, 1'b0);
      run(1'b0, 10'h001, 1'b0);
      run(1'b1, 10'h155, 1'b1);
      i_sample[1] = 10'h2aa;
      wait_on(1'b0);
      check_frame(1'b1, 10'h2aa);
      i_continuous = 1'b0;
      run(1'b0, 10'h200, 1'b0);
      wait_on(1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
